// >>> core/udr_defs.svh
`ifndef UDR_DEFS_SVH
`define UDR_DEFS_SVH

// ********************************************************************
// Sizes
// ********************************************************************
`define UDR_NUM_CH      4
`define UDR_NUM_EP      4
`define UDR_SEL_W       16

// ********************************************************************
// Register word offsets
// ********************************************************************
`define UDR_OFF_SEL0    6'h00
`define UDR_OFF_SEL3    6'h03
`define UDR_OFF_STAT    6'h04
`define UDR_OFF_MASK    6'h05
`define UDR_OFF_MODE    6'h06

// ********************************************************************
// Select register fields and reset values
// ********************************************************************
`define UDR_SEL_IN_LSB  1
`define UDR_SEL_OUT_LSB 6
`define UDR_SEL_MASK    16'h03de
`define UDR_SEL_RST     16'h0000
`define UDR_BYTE_RST    4'h0

// ********************************************************************
// Buffer state codes
// ********************************************************************
`define UDR_OUT_SINGLE  2'h3
`define UDR_OUT_DOUBLE  2'h2
`define UDR_IN_SINGLE   2'h0
`define UDR_IN_DOUBLE   2'h1

`endif

// >>> core/udr_pkg.sv
package udr_pkg;

  // Per-endpoint buffer state and FIFO access strobes.
  typedef struct packed {
    logic out_buffer_state_hi;
    logic out_buffer_state_lo;
    logic in_buffer_state_hi;
    logic in_buffer_state_lo;
    logic out_state_update;
    logic in_state_update;
    logic out_fifo_read;
    logic in_fifo_write;
  } udr_ep_event_type;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } udr_avs_req_type;

endpackage

// >>> core/udr_dma_request_gen.sv
// Function
// - A channel requests only while its DMA enable bit is one.
// - Selection is valid only with exactly one select bit set.
// - Selected OUT state updated to 11 single or 10 double raises a request.
// - That OUT update also pulses the endpoint OUT interrupt request.
// - Writing one OUT select into an empty register with data present requests.
// - Each OUT FIFO read with valid selection and data present requests again.
// - DMA packet reads start on any trigger and continue on FIFO-read triggers.
// - Selected IN state updated to 00 single or 01 double raises a request.
// - That IN update also pulses the endpoint IN interrupt request.
// - Writing one IN select into an empty register with space present requests.
// - Each IN FIFO write with valid selection and space present requests again.
// - DMA packet writes start on any trigger and continue on FIFO-write triggers.
// - A request needs the event and all its conditions in the same cycle.
// - Request source n drives DMA channel n, fixed one to one.
// - Select register: IN selects bits 1-4, OUT selects bits 6-9, reset zero.
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
`include "udr_defs.svh"
module udr_dma_request_gen
  import udr_pkg::*;
(
  // Clock and reset.
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // Avalon-MM register slave.
  input  wire udr_avs_req_type               avs_req,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  // Endpoint buffer state and FIFO accesses, endpoints 1 to 4.
  input  wire udr_ep_event_type [3:0]        ep_event,
  // DMA controller channels.
  input  wire logic [`UDR_NUM_CH-1:0]        dma_channel_en,
  output logic [`UDR_NUM_CH-1:0]             dma_channel_req,
  // Endpoint interrupt requests and block interrupt.
  output logic [`UDR_NUM_EP-1:0]             ep_out_irq,
  output logic [`UDR_NUM_EP-1:0]             ep_in_irq,
  output logic                               irq
);

  // ******************************************************************
  // Helper functions
  // ******************************************************************

  // True when exactly one of the defined select bits is set.
  function automatic logic sel_valid(input logic [15:0] sel);
    logic [15:0] m;
    m = sel & `UDR_SEL_MASK;
    return (m != `UDR_SEL_RST) && ((m & (m - 16'h0001)) == `UDR_SEL_RST);
  endfunction

  // Byte-lane merge of a 16-bit register.
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ******************************************************************
  // Register state
  // ******************************************************************
  logic [15:0]            usb_dma_source_select_r [`UDR_NUM_CH];
  logic [15:0]            usb_dma_source_select_nxt [`UDR_NUM_CH];
  logic [3:0]             stat_r, stat_nxt;
  logic [3:0]             mask_r, mask_nxt;
  logic [3:0]             mode_r, mode_nxt;
  logic                   ack_r, ack_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic [3:0]             req_r, req_nxt;
  logic [3:0]             oirq_r, oirq_nxt;
  logic [3:0]             iirq_r, iirq_nxt;

  // Per-endpoint decoded conditions.
  logic [3:0]             out_t1, in_t1, out_have, in_space, out_rd, in_wr;
  logic [5:0]             word_idx;
  logic                   wr_commit, rd_commit;
  logic [3:0]             sel_wr;
  logic [3:0]             hit_t1, hit_t2, hit_t3, sel_ok;

  assign word_idx  = avs_req.address[7:2];
  assign wr_commit = avs_req.write & ack_r;
  assign rd_commit = avs_req.read & ack_r;

  // ******************************************************************
  // Endpoint conditions
  // ******************************************************************
  genvar e, c;
  generate
    for (e = 0; e < `UDR_NUM_EP; e++) begin : g_ep
      logic [1:0] ost, ist;
      assign ost = {ep_event[e].out_buffer_state_hi, ep_event[e].out_buffer_state_lo};
      assign ist = {ep_event[e].in_buffer_state_hi, ep_event[e].in_buffer_state_lo};
      // Update to the full code of the buffer mode.
      assign out_t1[e]   = ep_event[e].out_state_update &
                           (ost == (mode_r[e] ? `UDR_OUT_DOUBLE : `UDR_OUT_SINGLE));
      assign in_t1[e]    = ep_event[e].in_state_update &
                           (ist == (mode_r[e] ? `UDR_IN_DOUBLE : `UDR_IN_SINGLE));
      // State 10 or 11 means received data, 00 or 01 means free space.
      assign out_have[e] = ost[1];
      assign in_space[e] = ~ist[1];
      assign out_rd[e]   = ep_event[e].out_fifo_read;
      assign in_wr[e]    = ep_event[e].in_fifo_write;
    end

    // ****************************************************************
    // Channel trigger decode
    // ****************************************************************
    for (c = 0; c < `UDR_NUM_CH; c++) begin : g_ch
      logic [3:0]  osel, isel, nosel, nisel;
      logic [15:0] newsel;
      assign osel   = usb_dma_source_select_r[c][`UDR_SEL_OUT_LSB +: 4];
      assign isel   = usb_dma_source_select_r[c][`UDR_SEL_IN_LSB +: 4];
      assign sel_wr[c] = wr_commit && (word_idx == (`UDR_OFF_SEL0 + 6'(c)));
      assign newsel = lane_merge(usb_dma_source_select_r[c], avs_req.writedata[15:0],
                                 avs_req.byteenable[1:0]) & `UDR_SEL_MASK;
      assign nosel  = newsel[`UDR_SEL_OUT_LSB +: 4];
      assign nisel  = newsel[`UDR_SEL_IN_LSB +: 4];
      assign sel_ok[c] = sel_valid(usb_dma_source_select_r[c]);
      // Buffer state update trigger.
      assign hit_t1[c] = |(osel & out_t1) | |(isel & in_t1);
      // First valid selection written into an empty register.
      assign hit_t2[c] = sel_wr[c] && (usb_dma_source_select_r[c] == `UDR_SEL_RST) &&
                         sel_valid(newsel) &&
                         (|(nosel & out_have) | |(nisel & in_space));
      // Each FIFO access on a selected endpoint with data or space present keeps the transfer going.
      assign hit_t3[c] = |(osel & out_have & out_rd) | |(isel & in_space & in_wr);
    end
  endgenerate

  // ******************************************************************
  // Channel select registers
  // ******************************************************************

  // Next select values; a write merges its byte lanes and drops reserved bits.
  always_comb begin
    for (int i = 0; i < `UDR_NUM_CH; i++) begin
      usb_dma_source_select_nxt[i] = usb_dma_source_select_r[i];
      if (sel_wr[i]) begin
        usb_dma_source_select_nxt[i] = lane_merge(usb_dma_source_select_r[i], avs_req.writedata[15:0],
                                                  avs_req.byteenable[1:0]) & `UDR_SEL_MASK;
      end
    end
  end

  // Registers the select values.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `UDR_NUM_CH; i++) begin
        usb_dma_source_select_r[i] <= `UDR_SEL_RST;
      end
    end else begin
      for (int i = 0; i < `UDR_NUM_CH; i++) begin
        usb_dma_source_select_r[i] <= usb_dma_source_select_nxt[i];
      end
    end
  end

  // ******************************************************************
  // Request and endpoint interrupt pulses
  // ******************************************************************

  // Channel n serves request source n only; enable gates all triggers.
  always_comb begin
    for (int i = 0; i < `UDR_NUM_CH; i++) begin
      req_nxt[i] = dma_channel_en[i] &
                   ((sel_ok[i] & (hit_t1[i] | hit_t3[i])) | hit_t2[i]);
    end
    // Endpoint interrupt requests come with the completion update.
    oirq_nxt = out_t1;
    iirq_nxt = in_t1;
  end

  // Registers the pulses, so that each one comes one cycle after its trigger and lasts as long as it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_r  <= `UDR_BYTE_RST;
      oirq_r <= `UDR_BYTE_RST;
      iirq_r <= `UDR_BYTE_RST;
    end else begin
      req_r  <= req_nxt;
      oirq_r <= oirq_nxt;
      iirq_r <= iirq_nxt;
    end
  end

  // ******************************************************************
  // Status, mask, mode and bus answer
  // ******************************************************************

  // Next bus-side values; the answer comes after exactly one wait cycle.
  always_comb begin
    // Mask and mode take the low byte lane only.
    mask_nxt = mask_r;
    mode_nxt = mode_r;
    if (wr_commit && avs_req.byteenable[0] && word_idx == `UDR_OFF_MASK) begin
      mask_nxt = avs_req.writedata[3:0];
    end
    if (wr_commit && avs_req.byteenable[0] && word_idx == `UDR_OFF_MODE) begin
      mode_nxt = avs_req.writedata[3:0];
    end
    // Sticky status, cleared by a read; a new request wins over the clear.
    stat_nxt = stat_r;
    if (rd_commit && word_idx == `UDR_OFF_STAT) begin
      stat_nxt = `UDR_BYTE_RST;
    end
    stat_nxt = stat_nxt | req_nxt;
    // One wait cycle, then the answer.
    ack_nxt   = (avs_req.read | avs_req.write) & ~ack_r;
    rdata_nxt = 32'h0000_0000;
    // Read data for the addressed register; unmapped offsets read zero.
    if (word_idx <= `UDR_OFF_SEL3) begin
      rdata_nxt[15:0] = usb_dma_source_select_r[word_idx[1:0]];
    end else if (word_idx == `UDR_OFF_STAT) begin
      rdata_nxt[3:0] = stat_r | req_nxt;
    end else if (word_idx == `UDR_OFF_MASK) begin
      rdata_nxt[3:0] = mask_r;
    end else if (word_idx == `UDR_OFF_MODE) begin
      rdata_nxt[3:0] = mode_r;
    end
  end

  // Registers the bus-side state.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_r  <= `UDR_BYTE_RST;
      mask_r  <= `UDR_BYTE_RST;
      mode_r  <= `UDR_BYTE_RST;
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      mode_r  <= mode_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs.
  assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign dma_channel_req = req_r;
  assign ep_out_irq      = oirq_r;
  assign ep_in_irq       = iirq_r;
  assign irq             = |(stat_r & mask_r);

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Per-channel request, select register and status checks.
  generate
    for (c = 0; c < `UDR_NUM_CH; c++) begin : g_ast
      AST_REQ_NEEDS_EN: assert property (dma_channel_req[c] |-> $past(dma_channel_en[c]))
        else $error("Request on a disabled channel.");
      AST_REQ_NEEDS_TRIGGER: assert property (dma_channel_req[c] |->
          $past(hit_t2[c] | (sel_valid(usb_dma_source_select_r[c]) & (hit_t1[c] | hit_t3[c]))))
        else $error("Request without a complete trigger.");
      AST_BAD_SEL_NO_T13: assert property (!sel_valid(usb_dma_source_select_r[c]) && !hit_t2[c]
          |=> !dma_channel_req[c])
        else $error("Request with an invalid selection.");
      AST_T1_REQ: assert property (dma_channel_en[c] && sel_ok[c] && hit_t1[c] |=> dma_channel_req[c])
        else $error("State update trigger gave no request.");
      AST_T2_REQ: assert property (dma_channel_en[c] && hit_t2[c] |=> dma_channel_req[c] &&
          (usb_dma_source_select_r[c] != `UDR_SEL_RST))
        else $error("Select write trigger gave no request.");
      AST_T3_OUT_REQ: assert property (dma_channel_en[c] && sel_ok[c] &&
          |(usb_dma_source_select_r[c][`UDR_SEL_OUT_LSB +: 4] & out_have & out_rd) |=> dma_channel_req[c])
        else $error("OUT FIFO read gave no request.");
      AST_T3_IN_REQ: assert property (dma_channel_en[c] && sel_ok[c] &&
          |(usb_dma_source_select_r[c][`UDR_SEL_IN_LSB +: 4] & in_space & in_wr) |=> dma_channel_req[c])
        else $error("IN FIFO write gave no request.");
      AST_PULSE: assert property (dma_channel_req[c] && !hit_t1[c] && !hit_t2[c] && !hit_t3[c]
          |=> !dma_channel_req[c])
        else $error("Request held without a new event.");
      AST_SEL_RESERVED: assert property ((usb_dma_source_select_r[c] & ~`UDR_SEL_MASK) == `UDR_SEL_RST)
        else $error("Reserved select bits set.");
      AST_STAT_SET: assert property (dma_channel_req[c] |-> stat_r[c])
        else $error("Request left no status bit.");
    end
  endgenerate

  AST_OUT_IRQ: assert property (|out_t1 |=> (ep_out_irq == $past(out_t1)))
    else $error("OUT interrupt missing with OUT update.");
  AST_IN_IRQ: assert property (|in_t1 |=> (ep_in_irq == $past(in_t1)))
    else $error("IN interrupt missing with IN update.");
  // Interrupt, status and bus checks.
  AST_STAT_CLEAR: assert property (rd_commit && (word_idx == `UDR_OFF_STAT)
      |=> stat_r == $past(req_nxt))
    else $error("Status read cleared a new request or kept an old one.");
  AST_MASK_WRITE: assert property (wr_commit && avs_req.byteenable[0] && (word_idx == `UDR_OFF_MASK)
      |=> mask_r == $past(avs_req.writedata[3:0]))
    else $error("Mask write did not land.");
  AST_IRQ_LEVEL: assert property ((stat_r & mask_r) != `UDR_BYTE_RST |-> irq)
    else $error("Unmasked status without interrupt.");
  AST_BUS_ANSWER: assert property ((avs_req.read | avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer later than one wait cycle.");

  // Main scenarios.
  COV_T1: cover property (hit_t1[0] && sel_ok[0] && dma_channel_en[0] ##1 dma_channel_req[0]);
  COV_T2: cover property (hit_t2[1] && dma_channel_en[1] ##1 dma_channel_req[1]);
  COV_T3_BURST: cover property (dma_channel_req[0] ##2 dma_channel_req[0] ##2 dma_channel_req[0]);
  COV_T3_IN: cover property (dma_channel_req[1] ##2 dma_channel_req[1]);
  COV_IRQ: cover property (!irq ##1 irq);

endmodule

// >>> test/udr_dma_model.sv
`timescale 1ns/1ns
// ********************************************************************
// DMA controller channel model
// ********************************************************************
module udr_dma_model
  import udr_pkg::*;
#(
  parameter int UNITS = 4
)(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Channel requests and transfer arming.
  input  wire logic [3:0] dma_channel_req,
  input  wire logic [3:0] arm,
  // One strobe per unit moved, and units moved since arming.
  output logic [3:0]      unit_strobe,
  output logic [3:0][7:0] unit_count
);
  // Each request while armed and below UNITS units moves one unit at a fixed FIFO address, and that access raises the next request.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unit_strobe <= 4'h0;
      unit_count  <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        unit_strobe[c] <= arm[c] && dma_channel_req[c] && unit_count[c] < 8'(UNITS);
        if (!arm[c]) unit_count[c] <= 8'h00;
        else if (dma_channel_req[c] && unit_count[c] < 8'(UNITS)) unit_count[c] <= unit_count[c] + 8'h01;
      end
    end
  end
endmodule

// >>> test/tb_usb_endpoint_dma_request_gen.sv
`timescale 1ns/1ns
// ********************************************************************
// Request generator bench
// ********************************************************************
module tb_usb_endpoint_dma_request_gen;
  import udr_pkg::*;
  localparam int UNITS = 4;
  logic                   clock = 1'b0;
  logic                   rst_n = 1'b0;
  udr_avs_req_type        avs_req;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  udr_ep_event_type [3:0] ev_r;
  udr_ep_event_type [3:0] ep_w;
  logic [3:0]             en;
  logic [3:0]             req;
  logic [3:0]             oirq;
  logic [3:0]             iirq;
  logic [3:0]             arm;
  logic [3:0]             strobe;
  logic [3:0][7:0]        ucnt;
  logic                   irq;
  logic [31:0]            rd;
  int n_req[4], n_oi[4], n_ii[4];
  int n_fail = 0, n_compared = 0, bt;

  // Clock at 125 MHz.
  always #4 clock = ~clock;

  // Model strobes act as FIFO reads on endpoint 1 and FIFO writes on endpoint 2.
  always_comb begin
    ep_w = ev_r;
    ep_w[0].out_fifo_read = ev_r[0].out_fifo_read | strobe[0];
    ep_w[1].in_fifo_write = ev_r[1].in_fifo_write | strobe[1];
  end

  // Counts request and interrupt pulses, one per high cycle.
  always @(posedge clock) if (rst_n) for (int i = 0; i < 4; i++) begin
    n_req[i] += req[i];
    n_oi[i] += oirq[i];
    n_ii[i] += iirq[i];
  end

  udr_dma_request_gen dut_u (.clock(clock), .rst_n(rst_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ep_event(ep_w), .dma_channel_en(en), .dma_channel_req(req),
    .ep_out_irq(oirq), .ep_in_irq(iirq), .irq(irq));
  udr_dma_model #(.UNITS(UNITS)) mdl_u (.clock(clock), .rst_n(rst_n), .dma_channel_req(req), .arm(arm),
    .unit_strobe(strobe), .unit_count(ucnt));

  function automatic int tot();
    return n_req[0] + n_req[1] + n_req[2] + n_req[3];
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low at a rising edge.
  task automatic bus(bit wr, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    avs_req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hf};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    rd = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  // Sets an endpoint state, optionally with an update or FIFO access pulse.
  task automatic ev(int e, bit o, logic [1:0] st, bit upd, bit acc);
    @(posedge clock);
    if (o) begin
      {ev_r[e].out_buffer_state_hi, ev_r[e].out_buffer_state_lo} <= st;
      ev_r[e].out_state_update <= upd;
      ev_r[e].out_fifo_read <= acc;
    end else begin
      {ev_r[e].in_buffer_state_hi, ev_r[e].in_buffer_state_lo} <= st;
      ev_r[e].in_state_update <= upd;
      ev_r[e].in_fifo_write <= acc;
    end
    @(posedge clock);
    {ev_r[e].out_state_update, ev_r[e].in_state_update, ev_r[e].out_fifo_read, ev_r[e].in_fifo_write} <= 4'h0;
    repeat (3) @(negedge clock);
  endtask

  // Checks the requests counted since the last call.
  task automatic delta(int exp);
    repeat (3) @(negedge clock);
    check(32'(tot() - bt), 32'(exp));
    bt = tot();
  endtask

  // Update pulse with the expected request on channel c and interrupt on endpoint e.
  task automatic step(int c, int e, bit o, logic [1:0] st, int dr, int di);
    int b, bi;
    b = n_req[c];
    bi = o ? n_oi[e] : n_ii[e];
    bt = tot();
    ev(e, o, st, 1'b1, 1'b0);
    check(32'(n_req[c] - b), 32'(dr));
    check(32'((o ? n_oi[e] : n_ii[e]) - bi), 32'(di));
    delta(dr);
  endtask

  task automatic t_regs();
    for (int c = 0; c < 4; c++) begin
      bus(1'b0, 8'(c * 4), 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0);
    bt = tot();
    bus(1'b1, 8'h0c, 32'hffff);
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h03de);
    delta(0);
    bus(1'b1, 8'h0c, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_trig1();
    for (int d = 0; d < 2; d++) for (int c = 0; c < 4; c++) begin
      ev(c, d[0], d ? 2'h0 : 2'h3, 1'b0, 1'b0);
      bus(1'b1, 8'(c * 4), d ? 32'h40 << c : 32'h2 << c);
      step(c, c, d[0], d ? 2'h3 : 2'h0, 1, 1);
      step(c, c, d[0], d ? 2'h2 : 2'h1, 0, 0);
      bus(1'b1, 8'h18, 32'h1 << c);
      step(c, c, d[0], d ? 2'h2 : 2'h1, 1, 1);
      @(posedge clock);
      en[c] <= 1'b0;
      step(c, c, d[0], d ? 2'h2 : 2'h1, 0, 1);
      @(posedge clock);
      en[c] <= 1'b1;
      bus(1'b1, 8'h18, 32'h0);
      bus(1'b1, 8'(c * 4), 32'h0);
    end
    $display("test trigger one done");
  endtask

  task automatic t_trig23();
    ev(0, 1'b1, 2'h2, 1'b0, 1'b0);
    bt = tot();
    bus(1'b1, 8'h00, 32'h40);
    delta(1);
    ev(0, 1'b1, 2'h2, 1'b0, 1'b1);
    delta(1);
    ev(1, 1'b1, 2'h2, 1'b0, 1'b1);
    delta(0);
    bus(1'b1, 8'h00, 32'h0);
    ev(0, 1'b1, 2'h0, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 32'h40);
    delta(0);
    bus(1'b1, 8'h00, 32'h0);
    ev(0, 1'b0, 2'h0, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 32'h2);
    delta(1);
    ev(0, 1'b0, 2'h0, 1'b0, 1'b1);
    delta(1);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h6);
    delta(0);
    bus(1'b1, 8'h00, 32'h0);
    $display("test triggers two and three done");
  endtask

  task automatic t_packet();
    for (int c = 0; c < 2; c++) begin
      ev(c, c == 0, c == 0 ? 2'h3 : 2'h0, 1'b0, 1'b0);
      @(posedge clock);
      arm[c] <= 1'b1;
      bt = tot();
      bus(1'b1, 8'(c * 4), c == 0 ? 32'h40 : 32'h4);
      repeat (30) @(negedge clock);
      check(32'(ucnt[c]), 32'(UNITS));
      delta(UNITS + 1);
      @(posedge clock);
      arm[c] <= 1'b0;
      bus(1'b1, 8'(c * 4), 32'h0);
    end
    $display("test packet done");
  endtask

  task automatic t_irq();
    bus(1'b1, 8'h14, 32'h0);
    @(negedge clock);
    check(32'(irq), 32'h0);
    bus(1'b1, 8'h14, 32'hf);
    @(negedge clock);
    check(32'(irq), 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'hf);
    @(negedge clock);
    check(32'(irq), 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    $display("test interrupt done");
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after a reset of 16 cycles.
  initial begin
    avs_req = '0;
    ev_r = '0;
    en = 4'hf;
    arm = 4'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_trig1();
    t_trig23();
    t_packet();
    t_irq();
    test_done();
  end

  // Watchdog cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    test_done();
  end
endmodule
